/* File: hw/hpio_pkg.sv */
// Purpose: shared constants for the host port and pcm stream ends
// Assumes: one system clock at 200 MHz on both ends
// Notes:   register offsets below are local choices of this design
package hpio_pkg;
  // ************************************************************
  // port widths
  // ************************************************************
  localparam int ADDR_W   = 13;
  localparam int DATA_W   = 8;
  localparam int CHANS    = 32;
  localparam int CH_W     = 5;
  localparam int BIT_W    = 3;

  // ************************************************************
  // register map and reset values
  // ************************************************************
  localparam logic [12:0] MAIN_CTRL_ADDR = 13'h0000;
  localparam logic [12:0] STATUS_ADDR    = 13'h0001;
  localparam logic [12:0] INT_FIFO_ADDR  = 13'h0002;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam int          CTRL_GATE_BIT  = 6;
  localparam int          INT_VALID_BIT  = 7;
  localparam logic [7:0]  EMPTY_ENTRY    = 8'h00;

  // ************************************************************
  // stream timing
  // ************************************************************
  localparam longint SYS_CLK_HZ     = 200000000;
  localparam longint BIT_CLK_HZ     = 4096000;
  localparam int     FRAME_BCLK     = 512;   // 32 ch x 8 bit x 2 clocks
  localparam int     PULSE_MAX_BCLK = 2;     // longest run taken as frame pulse
  // half period of the generated bit clock, rounded down
  localparam int     BCLK_HALF_CYC  = int'(SYS_CLK_HZ / (2 * BIT_CLK_HZ));

  // ************************************************************
  // host access sequencer
  // ************************************************************
  typedef enum logic [1:0] {
    HPIO_H_IDLE  = 2'b00,
    HPIO_H_SETUP = 2'b01,
    HPIO_H_STRB  = 2'b10,
    HPIO_H_REL   = 2'b11
  } hpio_hstate_t;
endpackage

/* File: hw/hpio_if.sv */
// Purpose: pin bundle between host processor/highway and the device
// Assumes: open-drain pins pulled high when nobody pulls low
// Notes:   wire levels are resolved here from the output enables
`timescale 1ns/1ps
interface hpio_if;
  logic        cs_n;
  logic        data_strobe_n;
  logic        rw;            // 1 = read
  logic [12:0] addr;
  logic [7:0]  d_host;
  logic        d_host_oe;
  logic [7:0]  d_dev;
  logic        d_dev_oe;
  logic [7:0]  d_bus;
  logic        ack_oe;        // pulls transfer_ack_n low
  logic        transfer_ack_n;
  logic        irq_oe;        // pulls irq_n low
  logic        irq_n;
  logic        output_drive_gate;
  logic        bit_shift_clock;
  logic        frame_sync_in;
  logic        sin;
  logic        rin;
  logic        sout;
  logic        sout_oe;
  logic        rout;
  logic        rout_oe;
  logic        sout_line;
  logic        rout_line;

  // ************************************************************
  // wire resolution, pull-ups give a high idle level
  // ************************************************************
  assign d_bus          = d_dev_oe ? d_dev : (d_host_oe ? d_host : 8'hff);
  assign transfer_ack_n = ~ack_oe;
  assign irq_n          = ~irq_oe;
  assign sout_line      = sout_oe ? sout : 1'b1;
  assign rout_line      = rout_oe ? rout : 1'b1;

  modport dev (
    input  cs_n, data_strobe_n, rw, addr, d_bus, output_drive_gate,
    input  bit_shift_clock, frame_sync_in, sin, rin,
    output d_dev, d_dev_oe, ack_oe, irq_oe, sout, sout_oe, rout, rout_oe
  );
  modport host (
    output cs_n, data_strobe_n, rw, addr, d_host, d_host_oe, output_drive_gate,
    output bit_shift_clock, frame_sync_in, sin, rin,
    input  d_bus, transfer_ack_n, irq_n, sout_line, rout_line
  );
endinterface

/* File: hw/hpio_dev.sv */
// Purpose: device end: processor port, interrupt queue, two pcm paths
// Assumes: pins arrive unsynchronised; bit clock far slower than i_sys_clk
// Notes:   echo processing is absent; each stream loops with one frame delay
// Notes on behaviour
// - irq pulled low while events pending
// - irq released once interrupt queue empty
// - access only with strobe and select low
// - host drives select low to access
// - read/write pin sets data direction
// - acknowledge pulled low when transfer done
// - data bus is eight bits wide
// - thirteen address lines select registers
// - pcm outputs on when gate pin and bit6
// - otherwise pcm outputs held high impedance
// - port 1 send output, 32-channel stream
// - port 2 receive output, 32-channel stream
// - port 2 send input, 32-channel stream
// - port 1 receive input, 32-channel stream
// - bits move on external 4.096 MHz clock
// - frame pulse format detected automatically
// - reset loads control registers with defaults
`timescale 1ns/1ps

// ************************************************************
// interrupt entry queue
// ************************************************************
module hpio_fifo
  import hpio_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
    $error("hpio_fifo: depth must be a power of two above one");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  logic [PW:0]      count_next;
  logic             ready_reg;
  wire              push = i_in_valid & ready_reg;
  wire              pop  = i_out_ready & (count_reg != '0);

  // occupancy after this cycle's push and pop
  assign count_next  = count_reg + (PW+1)'(push) - (PW+1)'(pop);
  assign o_in_ready  = ready_reg;
  assign o_out_valid = (count_reg != '0);
  assign o_out_data  = mem[rd_ptr_reg];

  // ready is a flop so a full queue stalls the event source cleanly
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      ready_reg  <= 1'b1;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + PW'(push);
      rd_ptr_reg <= rd_ptr_reg + PW'(pop);
      count_reg  <= count_next;
      ready_reg  <= (count_next != (PW+1)'(DEPTH));
    end
  end

  // storage carries no reset
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end
endmodule

// ************************************************************
// device end
// ************************************************************
module hpio_dev
  import hpio_pkg::*;
#(
  parameter int QDEPTH = 4
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  hpio_if.dev              bus,
  input  wire logic        i_evt_valid,
  input  wire logic [4:0]  i_evt_chan,
  output logic             o_evt_ready,
  output logic [7:0]       o_main_ctrl,
  output logic             o_fmt_high
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  localparam int SN = 7;
  wire  [SN-1:0] pin_raw = {bus.cs_n, bus.data_strobe_n, bus.output_drive_gate,
                            bus.bit_shift_clock, bus.frame_sync_in, bus.sin, bus.rin};
  logic [SN-1:0] s1_reg;
  logic [SN-1:0] s2_reg;
  logic          bclk_prev_reg;

  // idle levels keep a reset from looking like an access
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s1_reg        <= 7'h60;
      s2_reg        <= 7'h60;
      bclk_prev_reg <= 1'b0;
    end else begin
      s1_reg        <= pin_raw;
      s2_reg        <= s1_reg;
      bclk_prev_reg <= s2_reg[3];
    end
  end

  wire       cs_s    = s2_reg[6];
  wire       ds_s    = s2_reg[5];
  wire       gate_s  = s2_reg[4];
  wire       fs_s    = s2_reg[2];
  wire [1:0] din_s   = {s2_reg[0], s2_reg[1]}; // index 0 send in, 1 receive in
  wire       bclk_up = s2_reg[3] & ~bclk_prev_reg;

  // ************************************************************
  // processor port
  // ************************************************************
  logic       ack_reg;
  logic       d_oe_reg;
  logic [7:0] rdata_reg;
  logic [7:0] ctrl_reg;
  logic       fmt_reg;
  logic       irq_reg;
  logic       q_valid;
  logic [7:0] q_data;
  logic       q_ready;

  // address and direction are steady well before the synced strobe
  wire        access  = ~cs_s & ~ds_s;
  wire        start   = access & ~ack_reg;
  wire        is_rd   = bus.rw;
  wire        hit_ctl = (bus.addr == MAIN_CTRL_ADDR);
  wire        hit_sts = (bus.addr == STATUS_ADDR);
  wire        hit_int = (bus.addr == INT_FIFO_ADDR);
  wire        pop     = start & is_rd & hit_int;
  wire [7:0]  int_rd  = q_valid ? q_data : EMPTY_ENTRY;
  wire [7:0]  sts_rd  = {6'h00, irq_reg, fmt_reg};
  wire [7:0]  rd_mux;

  // unmapped addresses read as zero and ignore writes
  assign rd_mux = hit_ctl ? ctrl_reg : (hit_sts ? sts_rd : (hit_int ? int_rd : 8'h00));

  // one transfer per strobe; ack holds until the strobe goes away
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ack_reg   <= 1'b0;
      d_oe_reg  <= 1'b0;
      rdata_reg <= 8'h00;
      ctrl_reg  <= CTRL_RESET;
    end else if (!access) begin
      ack_reg   <= 1'b0;
      d_oe_reg  <= 1'b0;
    end else if (start) begin
      ack_reg   <= 1'b1;
      d_oe_reg  <= is_rd;
      rdata_reg <= rd_mux;
      if (!is_rd && hit_ctl) begin
        ctrl_reg <= bus.d_bus;
      end
    end
  end

  assign bus.d_dev    = rdata_reg;
  assign bus.d_dev_oe = d_oe_reg;
  assign bus.ack_oe   = ack_reg;
  assign o_main_ctrl  = ctrl_reg;

  // ************************************************************
  // interrupt queue and request pin
  // ************************************************************
  // a full queue back-pressures the event source rather than losing entries
  hpio_fifo #(.WIDTH(8), .DEPTH(QDEPTH)) hpio_fifo_inst (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_in_valid  (i_evt_valid),
    .o_in_ready  (q_ready),
    .i_in_data   ({1'b1, 2'b00, i_evt_chan}),
    .o_out_valid (q_valid),
    .i_out_ready (pop),
    .o_out_data  (q_data)
  );
  assign o_evt_ready = q_ready;

  // request follows queue occupancy one cycle later
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= q_valid;
    end
  end
  assign bus.irq_oe = irq_reg;

  // ************************************************************
  // frame alignment and format detection
  // ************************************************************
  logic [8:0] bpos_reg;
  logic       fs_prev_reg;
  logic [1:0] run_reg;
  logic       oe_reg;
  wire        fs_edge  = bclk_up & (fs_s != fs_prev_reg);
  wire        fs_pulse = fs_edge & (run_reg <= 2'(PULSE_MAX_BCLK));
  wire [4:0]  ch       = bpos_reg[8:4];
  wire [2:0]  bitn     = bpos_reg[3:1];

  // a short run ending marks a frame pulse; its level names the format
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      bpos_reg    <= 9'h000;
      fs_prev_reg <= 1'b1;
      run_reg     <= 2'h3;
      fmt_reg     <= 1'b0;
      oe_reg      <= 1'b0;
    end else begin
      oe_reg <= gate_s & ctrl_reg[CTRL_GATE_BIT];
      if (bclk_up) begin
        fs_prev_reg <= fs_s;
        run_reg     <= fs_edge ? 2'h1 : ((run_reg == 2'h3) ? run_reg : run_reg + 2'h1);
        // the pulse rise itself is position 0, so the next rise is position 1
        bpos_reg    <= fs_pulse ? 9'h001 : bpos_reg + 9'h001;
        if (fs_pulse) begin
          fmt_reg <= fs_prev_reg;
        end
      end
    end
  end
  assign o_fmt_high = fmt_reg;

  // ************************************************************
  // two stream paths: send in to send out, receive in to receive out
  // ************************************************************
  logic [1:0] dout_reg;
  for (genvar p = 0; p < 2; p++) begin : g_path
    logic [7:0] mem [CHANS];
    logic [7:0] rx_reg;
    logic [7:0] tx_reg;
    wire  [7:0] rx_byte = {rx_reg[6:0], din_s[p]};

    // sample mid-bit, drive at bit start, msb first, 32 slots per frame
    always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
        rx_reg      <= 8'h00;
        tx_reg      <= 8'h00;
        dout_reg[p] <= 1'b1;
      end else if (bclk_up && bpos_reg[0]) begin
        rx_reg <= rx_byte;
      end else if (bclk_up) begin
        dout_reg[p] <= (bitn == 3'h0) ? mem[ch][7] : tx_reg[7];
        tx_reg      <= (bitn == 3'h0) ? {mem[ch][6:0], 1'b0} : {tx_reg[6:0], 1'b0};
      end
    end

    // a slot's byte is replayed in the same slot of the next frame
    always_ff @(posedge i_sys_clk) begin
      if (bclk_up && bpos_reg[0] && bitn == 3'h7) begin
        mem[ch] <= rx_byte;
      end
    end
  end

  assign bus.sout    = dout_reg[0];
  assign bus.rout    = dout_reg[1];
  assign bus.sout_oe = oe_reg;
  assign bus.rout_oe = oe_reg;
endmodule

/* File: hw/hpio_host.sv */
// Purpose: host end: processor access sequencer and pcm highway source
// Assumes: one command at a time; bit clock divided from i_sys_clk
// Notes:   bit clock is 4.167 MHz at 200 MHz, close to nominal
`timescale 1ns/1ps
module hpio_host
  import hpio_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  hpio_if.host             bus,
  input  wire logic        i_cmd_valid,
  input  wire logic        i_cmd_read,
  input  wire logic [12:0] i_cmd_addr,
  input  wire logic [7:0]  i_cmd_wdata,
  output logic             o_cmd_ready,
  output logic             o_rsp_valid,
  output logic [7:0]       o_rsp_data,
  output logic             o_irq,
  input  wire logic        i_out_gate,
  input  wire logic        i_fmt_high,
  input  wire logic [7:0]  i_pcm_byte,
  output logic [7:0]       o_pcm_rx
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [10:0] s1_reg;
  logic [10:0] s2_reg;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s1_reg <= 11'h7ff;
      s2_reg <= 11'h7ff;
    end else begin
      s1_reg <= {bus.transfer_ack_n, bus.irq_n, bus.sout_line, bus.d_bus};
      s2_reg <= s1_reg;
    end
  end
  wire ack_s = ~s2_reg[10];

  // ************************************************************
  // access sequencer: setup, strobe until ack, release until ack drops
  // ************************************************************
  hpio_hstate_t st_reg;
  logic         cs_n_reg;
  logic         ds_n_reg;
  logic         rw_reg;
  logic [12:0]  addr_reg;
  logic [7:0]   wd_reg;
  logic         doe_reg;
  logic         rsp_reg;
  logic [7:0]   rd_reg;
  logic         rdy_reg;
  logic         irq_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_reg   <= HPIO_H_IDLE;
      cs_n_reg <= 1'b1;
      ds_n_reg <= 1'b1;
      rw_reg   <= 1'b1;
      addr_reg <= 13'h0000;
      wd_reg   <= 8'h00;
      doe_reg  <= 1'b0;
      rsp_reg  <= 1'b0;
      rd_reg   <= 8'h00;
      rdy_reg  <= 1'b0;
      irq_reg  <= 1'b0;
    end else begin
      irq_reg <= ~s2_reg[9];
      rsp_reg <= 1'b0;
      case (st_reg)
        HPIO_H_IDLE: begin
          rdy_reg <= 1'b1;
          if (i_cmd_valid && rdy_reg) begin
            rdy_reg  <= 1'b0;
            rw_reg   <= i_cmd_read;
            addr_reg <= i_cmd_addr;
            wd_reg   <= i_cmd_wdata;
            doe_reg  <= ~i_cmd_read;
            cs_n_reg <= 1'b0;
            st_reg   <= HPIO_H_SETUP;
          end
        end
        HPIO_H_SETUP: begin
          ds_n_reg <= 1'b0;
          st_reg   <= HPIO_H_STRB;
        end
        HPIO_H_STRB: begin
          if (ack_s) begin
            rd_reg   <= s2_reg[7:0];
            rsp_reg  <= 1'b1;
            ds_n_reg <= 1'b1;
            cs_n_reg <= 1'b1;
            doe_reg  <= 1'b0;
            st_reg   <= HPIO_H_REL;
          end
        end
        default: begin
          if (!ack_s) begin
            st_reg <= HPIO_H_IDLE;
          end
        end
      endcase
    end
  end

  assign bus.cs_n          = cs_n_reg;
  assign bus.data_strobe_n = ds_n_reg;
  assign bus.rw            = rw_reg;
  assign bus.addr          = addr_reg;
  assign bus.d_host        = wd_reg;
  assign bus.d_host_oe     = doe_reg;
  assign o_cmd_ready       = rdy_reg;
  assign o_rsp_valid       = rsp_reg;
  assign o_rsp_data        = rd_reg;
  assign o_irq             = irq_reg;

  // ************************************************************
  // highway: bit clock, frame pulse, both input streams
  // ************************************************************
  logic [7:0] div_reg;
  logic       bclk_reg;
  logic [8:0] hpos_reg;
  logic       fs_reg;
  logic       dat_reg;
  logic       gate_reg;
  logic [7:0] rx_sh_reg;
  logic [7:0] rx_reg;
  wire        tick = (div_reg == 8'(BCLK_HALF_CYC - 1));
  wire        rise = tick & ~bclk_reg;
  wire [8:0]  hnext = hpos_reg + 9'h001;

  // pulse lasts the last bit clock of a frame, polarity per format input
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      div_reg   <= 8'h00;
      bclk_reg  <= 1'b0;
      hpos_reg  <= 9'h000;
      fs_reg    <= 1'b0;
      dat_reg   <= 1'b1;
      gate_reg  <= 1'b0;
      rx_sh_reg <= 8'h00;
      rx_reg    <= 8'h00;
    end else begin
      gate_reg <= i_out_gate;
      div_reg  <= tick ? 8'h00 : div_reg + 8'h01;
      if (tick) begin
        bclk_reg <= ~bclk_reg;
      end
      if (rise) begin
        hpos_reg <= hnext;
        fs_reg   <= (hnext == 9'(FRAME_BCLK - 1)) ? i_fmt_high : ~i_fmt_high;
        dat_reg  <= i_pcm_byte[3'h7 - hnext[3:1]];
        if (hpos_reg[0]) begin
          rx_sh_reg <= {rx_sh_reg[6:0], s2_reg[8]};
          if (hpos_reg[8:1] == 8'h07) begin
            rx_reg <= {rx_sh_reg[6:0], s2_reg[8]};
          end
        end
      end
    end
  end

  assign bus.bit_shift_clock   = bclk_reg;
  assign bus.frame_sync_in     = fs_reg;
  assign bus.sin               = dat_reg;
  assign bus.rin               = dat_reg;
  assign bus.output_drive_gate = gate_reg;
  assign o_pcm_rx              = rx_reg;
endmodule

/* File: sim/hpio_chk.sv */
// Purpose: pin-level checks on the link between host end and device end
// Assumes: one clock domain, interface signals wired in as plain inputs
// Notes:   windows allow for the two-flop synchronisers on each end
`timescale 1ns/1ps
module hpio_chk (
  input  wire logic  i_sys_clk,
  input  wire logic  i_rst,
  input  wire logic  cs_n,
  input  wire logic  data_strobe_n,
  input  wire logic  rw,
  input  wire logic  ack_oe,
  input  wire logic  d_dev_oe,
  input  wire logic  irq_oe,
  input  wire logic  output_drive_gate,
  input  wire logic  sout_oe,
  input  wire logic  rout_oe
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  // ************************************************************
  // processor port
  // ************************************************************
  a_ack_in_strobe: assert property ($rose(ack_oe) |-> !cs_n && !data_strobe_n)
    else $error("acknowledge raised outside select and strobe");
  a_ack_on_time: assert property ($fell(data_strobe_n) && !cs_n |-> ##[2:4] ack_oe)
    else $error("acknowledge late after strobe");
  a_ack_holds: assert property ($rose(ack_oe) |=> ack_oe [*3])
    else $error("acknowledge too short");
  a_ack_release: assert property ($rose(data_strobe_n) |-> ##[1:4] !ack_oe)
    else $error("acknowledge not released");
  a_read_drives: assert property ($rose(ack_oe) |-> d_dev_oe == rw)
    else $error("data drive does not follow direction");
  a_drive_in_ack: assert property (d_dev_oe |-> ack_oe)
    else $error("data driven outside transfer");

  // ************************************************************
  // interrupt and stream gating
  // ************************************************************
  // the request may only drop around a queue read
  a_irq_pop_only: assert property ($fell(irq_oe) |-> $past(ack_oe, 1) || $past(ack_oe, 2) || $past(ack_oe, 3))
    else $error("interrupt released without a read");
  a_gate_low_off: assert property (!output_drive_gate [*4] |-> !sout_oe && !rout_oe)
    else $error("stream output driven with gate low");
  a_outs_paired: assert property ((sout_oe == rout_oe) && (!sout_oe || $past(output_drive_gate, 3)))
    else $error("stream outputs enabled apart");
endmodule

/* File: sim/host_port_and_pcm_stream_io_tb.sv */
// Purpose: host end against device end, scenarios judged at user ports and bus pins
// Assumes: inputs change at falling edge; 5 ns clock
// Notes:   stream test waits up to three frames, the bulk of the run
`timescale 1ns/1ps
module host_port_and_pcm_stream_io_tb;
  import hpio_pkg::*;
  logic        i_sys_clk;
  logic        i_rst;
  logic        cmd_valid;
  logic        cmd_read;
  logic        cmd_ready;
  logic        rsp_valid;
  logic        irq;
  logic        out_gate;
  logic        fmt_high;
  logic        fmt_seen;
  logic        evt_valid;
  logic        evt_ready;
  logic [4:0]  evt_chan;
  logic [12:0] cmd_addr;
  logic [7:0]  cmd_wdata;
  logic [7:0]  rsp_data;
  logic [7:0]  pcm_byte;
  logic [7:0]  pcm_rx;
  logic [7:0]  main_ctrl;
  logic [7:0]  rd;
  int          fail_count;
  int          cmp_count;
  int          cyc;

  hpio_if bus_if ();
  hpio_dev #(.QDEPTH(4)) hpio_dev_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .bus(bus_if.dev),
    .i_evt_valid(evt_valid), .i_evt_chan(evt_chan), .o_evt_ready(evt_ready), .o_main_ctrl(main_ctrl),
    .o_fmt_high(fmt_seen));
  hpio_host hpio_host_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .bus(bus_if.host), .i_cmd_valid(cmd_valid),
    .i_cmd_read(cmd_read), .i_cmd_addr(cmd_addr), .i_cmd_wdata(cmd_wdata), .o_cmd_ready(cmd_ready),
    .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .o_irq(irq), .i_out_gate(out_gate),
    .i_fmt_high(fmt_high), .i_pcm_byte(pcm_byte), .o_pcm_rx(pcm_rx));
  hpio_chk hpio_chk_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .cs_n(bus_if.cs_n),
    .data_strobe_n(bus_if.data_strobe_n), .rw(bus_if.rw), .ack_oe(bus_if.ack_oe), .d_dev_oe(bus_if.d_dev_oe),
    .irq_oe(bus_if.irq_oe), .output_drive_gate(bus_if.output_drive_gate), .sout_oe(bus_if.sout_oe),
    .rout_oe(bus_if.rout_oe));

  // ************************************************************
  // clock, hang guard, shared tasks
  // ************************************************************
  always #2.5 i_sys_clk = ~i_sys_clk;

  // ceiling covers three frames of stream traffic plus the short tests
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 95000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // one host command, held until taken; read data lands in rd
  task automatic acc(input logic rd_en, input logic [12:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 60) begin
      @(negedge i_sys_clk);
      n++;
    end
    cmd_valid = 1'b1;
    cmd_read = rd_en;
    cmd_addr = a;
    cmd_wdata = wd;
    @(negedge i_sys_clk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 120) begin
      @(negedge i_sys_clk);
      n++;
    end
    rd = rsp_data;
    check({7'h00, rsp_valid}, 8'h01);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_regs();
    acc(1'b1, MAIN_CTRL_ADDR, 8'h00);
    check(rd, CTRL_RESET);
    acc(1'b0, MAIN_CTRL_ADDR, 8'h40);
    acc(1'b1, MAIN_CTRL_ADDR, 8'h00);
    check(rd, 8'h40);
    acc(1'b0, 13'h1000, 8'h00);
    acc(1'b0, STATUS_ADDR, 8'hff);
    check(main_ctrl, 8'h40);
    acc(1'b1, 13'h1fff, 8'h00);
    check(rd, 8'h00);
    acc(1'b1, INT_FIFO_ADDR, 8'h00);
    check(rd, EMPTY_ENTRY);
    $display("test regs finished");
  endtask

  task automatic t_irq();
    int i;
    evt_valid = 1'b1;
    for (i = 1; i <= 7; i++) begin
      evt_chan = (i > 4) ? 5'h05 : 5'(i);
      @(negedge i_sys_clk);
    end
    evt_valid = 1'b0;
    check({7'h00, evt_ready}, 8'h00);
    repeat (10) @(negedge i_sys_clk);
    check({6'h00, irq, bus_if.irq_n}, 8'h02);
    acc(1'b1, STATUS_ADDR, 8'h00);
    check(rd, 8'h02);
    acc(1'b1, INT_FIFO_ADDR, 8'h00);
    check(rd, 8'h81);
    check({7'h00, evt_ready}, 8'h01);
    evt_valid = 1'b1;
    @(negedge i_sys_clk);
    evt_valid = 1'b0;
    for (i = 2; i <= 5; i++) begin
      check({7'h00, irq}, 8'h01);
      acc(1'b1, INT_FIFO_ADDR, 8'h00);
      check(rd, {3'b100, 5'(i)});
    end
    repeat (12) @(negedge i_sys_clk);
    check({6'h00, irq, bus_if.irq_n}, 8'h01);
    acc(1'b1, INT_FIFO_ADDR, 8'h00);
    check(rd, EMPTY_ENTRY);
    $display("test irq finished");
  endtask

  task automatic t_stream();
    int n;
    int i;
    out_gate = 1'b1;
    pcm_byte = 8'ha5;
    n = 0;
    while (pcm_rx !== 8'ha5 && n < 80000) begin
      @(negedge i_sys_clk);
      n++;
    end
    check(pcm_rx, 8'ha5);
    check({6'h00, bus_if.sout_oe, bus_if.rout_oe}, 8'h03);
    check({7'h00, fmt_seen}, 8'h00);
    // slot 1 now leaves both outputs, msb first, one bit per 96 system cycles
    repeat (4) @(negedge i_sys_clk);
    for (i = 7; i >= 0; i--) begin
      check({6'h00, bus_if.sout_line, bus_if.rout_line}, {6'h00, pcm_byte[i], pcm_byte[i]});
      repeat (96) @(negedge i_sys_clk);
    end
    fmt_high = 1'b1;
    out_gate = 1'b0;
    repeat (8) @(negedge i_sys_clk);
    check({4'h0, bus_if.sout_oe, bus_if.rout_oe, bus_if.sout_line, bus_if.rout_line}, 8'h03);
    out_gate = 1'b1;
    acc(1'b0, MAIN_CTRL_ADDR, 8'h00);
    repeat (8) @(negedge i_sys_clk);
    check({6'h00, bus_if.sout_oe, bus_if.rout_oe}, 8'h00);
    repeat (27000) @(negedge i_sys_clk);
    check({7'h00, fmt_seen}, 8'h01);
    acc(1'b1, STATUS_ADDR, 8'h00);
    check(rd, 8'h01);
    $display("test stream finished");
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    i_sys_clk = 1'b0;
    i_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_addr = 13'h0000;
    cmd_wdata = 8'h00;
    out_gate = 1'b0;
    fmt_high = 1'b0;
    evt_valid = 1'b0;
    evt_chan = 5'h00;
    pcm_byte = 8'h3c;
    fail_count = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (4) @(negedge i_sys_clk);
    i_rst = 1'b0;
    repeat (3) @(negedge i_sys_clk);
    t_regs();
    t_irq();
    t_stream();
    test_done();
  end
endmodule
